// ---- core/wdt_ctrl.sv ----
// Purpose: watchdog with one guarded control register on AXI4-Lite
// Assumes: one AXI transaction stands for one processor instruction
// Notes:   counts crystal ticks; a timeout resets or interrupts
module wdt_ctrl
#(
    parameter int unsigned TICK_NUM = 32768,
    parameter int unsigned TICK_DEN = 40000000
)
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // AXI4-Lite write address and data
    input  wire logic [wdt_pkg::WDT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [wdt_pkg::WDT_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read
    input  wire logic [wdt_pkg::WDT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [wdt_pkg::WDT_DATA_W-1:0]     s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // system side
    input  wire logic                          supplyMonitorIrq,
    output logic                               sysResetReq,
    output logic                               wdtIrq,
    output logic                               wdtIrqPrioHigh,
    output logic                               irq
);
    import wdt_pkg::*;

    // timeout length in crystal ticks for prescale 0..7
    function automatic logic [WDT_CNT_W-1:0] timeoutTicks(
        input logic [3:0] p);
        timeoutTicks = WDT_CNT_W'(1) << (WDT_BASE_SHIFT + int'(p[2:0]));
    endfunction

    // control fields
    logic [3:0]            pre;
    logic                  isel;
    logic                  timeout_status_flag;
    logic                  serviceBit;
    logic                  unlockArmed;
    // counter and events
    logic [WDT_CNT_W-1:0]  tickCnt;
    logic                  xtalTick;
    logic                  timeoutEv;
    logic [2:0]            rstCnt;
    logic [WDT_EV_W-1:0]   irqStat;
    logic [WDT_EV_W-1:0]   irqMask;
    // bus capture
    logic                  awHeld;
    logic                  wHeld;
    logic [WDT_ADDR_W-1:0] awAddr;
    logic [7:0]            wByte;
    logic                  wLane0;
    logic                  doWrite;
    logic                  doRead;
    logic                  ctrlWrite;
    logic                  ctrlLoad;
    logic                  ctrlArm;
    logic                  anyAccess;
    logic [WDT_EV_W-1:0]   evSet;
    logic                  writeOk;

    wdt_tick_gen #(
        .TICK_NUM (TICK_NUM),
        .TICK_DEN (TICK_DEN)
    ) u_tick (
        .clk      (clk),
        .rst      (rst),
        .xtalTick (xtalTick)
    );

    // write channel: address and data may arrive in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
    assign doRead        = s_axi_arvalid && s_axi_arready;
    assign writeOk       = (awAddr == WDT_OFS_CTRL)
                        || (awAddr == WDT_OFS_IRQ_STAT)
                        || (awAddr == WDT_OFS_IRQ_MASK);

    // capture address and data until both are present
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awAddr <= '0;
            wByte  <= 8'h00;
            wLane0 <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            else if (doWrite)
            begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld  <= 1'b1;
                wByte  <= s_axi_wdata[7:0];
                wLane0 <= s_axi_wstrb[0];
            end
            else if (doWrite)
            begin
                wHeld <= 1'b0;
            end
        end
    end

    // write response, one cycle after both halves are in
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= WDT_RESP_OKAY;
        end
        else if (doWrite)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= writeOk ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read data is registered; unmapped reads answer zero and SLVERR
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= WDT_RESP_OKAY;
        end
        else if (doRead)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= WDT_RESP_OKAY;
            unique case (s_axi_araddr)
                WDT_OFS_CTRL:
                    s_axi_rdata <= {24'h0, pre, isel, timeout_status_flag, serviceBit,
                                    unlockArmed};
                WDT_OFS_IRQ_STAT:
                    s_axi_rdata <= {29'h0, irqStat};
                WDT_OFS_IRQ_MASK:
                    s_axi_rdata <= {29'h0, irqMask};
                WDT_OFS_COUNT:
                    s_axi_rdata <= {15'h0, tickCnt};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= WDT_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // a control write is the unlock step, the guarded load, or a refused locked write
    assign ctrlWrite = doWrite && wLane0 && (awAddr == WDT_OFS_CTRL);
    assign ctrlLoad  = ctrlWrite && unlockArmed;
    assign ctrlArm   = ctrlWrite && !unlockArmed
                    && wByte[WDT_BIT_UNLOCK];
    assign anyAccess = doWrite || doRead;

    // unlock lives for exactly one following transaction
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            unlockArmed <= 1'b0;
        else if (ctrlArm)
            unlockArmed <= 1'b1;
        else if (anyAccess)
            unlockArmed <= 1'b0;
    end

    // timeout: a service load in the same cycle wins, so it never races
    always_comb
    begin
        timeoutEv = 1'b0;
        if (serviceBit && !ctrlLoad)
        begin
            if (pre >= WDT_PRE_IMMED)
                timeoutEv = 1'b1;
            else if (xtalTick && tickCnt == timeoutTicks(pre) - 1'b1)
                timeoutEv = 1'b1;
        end
    end

    // crystal tick counter, cleared by service and on every timeout
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tickCnt <= '0;
        else if (ctrlLoad && wByte[WDT_BIT_SERVICE])
            tickCnt <= '0;
        else if (timeoutEv || !serviceBit)
            tickCnt <= '0;
        else if (xtalTick)
            tickCnt <= tickCnt + 1'b1;
    end

    // control fields; the status flag survives a watchdog reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pre        <= WDT_CTRL_RESET[WDT_PRE_MSB:WDT_PRE_LSB];
            isel       <= WDT_CTRL_RESET[WDT_BIT_ISEL];
            timeout_status_flag        <= WDT_CTRL_RESET[WDT_BIT_STATUS];
            serviceBit <= WDT_CTRL_RESET[WDT_BIT_SERVICE];
        end
        else
        begin
            if (ctrlLoad)
            begin
                pre        <= wByte[WDT_PRE_MSB:WDT_PRE_LSB];
                isel       <= wByte[WDT_BIT_ISEL];
                timeout_status_flag        <= wByte[WDT_BIT_STATUS];
                serviceBit <= wByte[WDT_BIT_SERVICE];
            end
            if (timeoutEv)
                timeout_status_flag <= 1'b1;
            if (timeoutEv && !isel)
                serviceBit <= 1'b0;
            if (supplyMonitorIrq)
                serviceBit <= 1'b0;
        end
    end

    // system reset request, held a few cycles for the reset tree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rstCnt <= 3'h0;
        else if (timeoutEv && !isel)
            rstCnt <= WDT_RST_PULSE_N;
        else if (rstCnt != 3'h0)
            rstCnt <= rstCnt - 1'b1;
    end
    assign sysResetReq = (rstCnt != 3'h0);

    // watchdog interrupt: ignores global enable, cleared by a control load
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wdtIrq <= 1'b0;
        else if (timeoutEv && isel)
            wdtIrq <= 1'b1;
        else if (ctrlLoad)
            wdtIrq <= 1'b0;
    end

    // priority is hardwired; there is no register that could lower it
    assign wdtIrqPrioHigh = 1'b1;

    // sticky event bits, write one to clear, a new event beats the clear
    always_comb
    begin
        evSet                  = '0;
        evSet[WDT_EV_TIMEOUT]  = timeoutEv;
        evSet[WDT_EV_SYSRESET] = timeoutEv && !isel;
        evSet[WDT_EV_REFUSED]  = ctrlWrite && !unlockArmed && !ctrlArm;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irqStat <= WDT_EV_RESET;
        else if (doWrite && wLane0 && awAddr == WDT_OFS_IRQ_STAT)
            irqStat <= (irqStat & ~wByte[WDT_EV_W-1:0]) | evSet;
        else
            irqStat <= irqStat | evSet;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irqMask <= WDT_EV_RESET;
        else if (doWrite && wLane0 && awAddr == WDT_OFS_IRQ_MASK)
            irqMask <= wByte[WDT_EV_W-1:0];
    end

    assign irq = |(irqStat & irqMask);

    // checks
    sequence s_reset_pulse;
        sysResetReq [*4];
    endsequence

    sequence s_locked_write;
        ctrlWrite && !unlockArmed;
    endsequence

    property p_timeout_period;
        @(posedge clk) disable iff (rst)
        (timeoutEv && pre < WDT_PRE_IMMED)
            |-> (xtalTick && tickCnt == timeoutTicks(pre) - 1'b1);
    endproperty
    a_timeout_period: assert property (p_timeout_period)
        else $error("timeout fired at the wrong count");

    property p_prescale_field;
        @(posedge clk) disable iff (rst)
        ctrlLoad |=> pre == $past(wByte[7:4]);
    endproperty
    a_prescale_field: assert property (p_prescale_field)
        else $error("prescale not taken from bits 7 to 4");

    property p_immediate;
        @(posedge clk) disable iff (rst)
        (serviceBit && pre == WDT_PRE_IMMED && !ctrlLoad) |-> timeoutEv;
    endproperty
    a_immediate: assert property (p_immediate)
        else $error("prescale 8 did not time out at once");

    property p_reset_mode;
        @(posedge clk) disable iff (rst)
        (timeoutEv && !isel) |=> s_reset_pulse ##1 !sysResetReq;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("reset request not four cycles long");

    property p_irq_mode;
        @(posedge clk) disable iff (rst)
        (timeoutEv && isel) |=> (wdtIrq && !sysResetReq);
    endproperty
    a_irq_mode: assert property (p_irq_mode)
        else $error("interrupt mode timeout gave no interrupt");

    property p_priority;
        @(posedge clk) disable iff (rst)
        wdtIrq |-> wdtIrqPrioHigh;
    endproperty
    a_priority: assert property (p_priority)
        else $error("watchdog interrupt lost its high priority");

    property p_interval;
        @(posedge clk) disable iff (rst)
        (timeoutEv && isel && !supplyMonitorIrq)
            |=> (serviceBit && tickCnt == '0);
    endproperty
    a_interval: assert property (p_interval)
        else $error("interval timer did not restart");

    property p_status_set;
        @(posedge clk) disable iff (rst)
        timeoutEv |=> timeout_status_flag;
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("timeout status flag not set");

    property p_status_kept;
        @(posedge clk) disable iff (rst)
        (sysResetReq && !$past(ctrlLoad) && $past(timeout_status_flag)) |-> timeout_status_flag;
    endproperty
    a_status_kept: assert property (p_status_kept)
        else $error("watchdog reset cleared the status flag");

    property p_service_clears;
        @(posedge clk) disable iff (rst)
        (ctrlLoad && wByte[WDT_BIT_SERVICE]) |=> tickCnt == '0;
    endproperty
    a_service_clears: assert property (p_service_clears)
        else $error("service did not clear the counter");

    property p_service_drop;
        @(posedge clk) disable iff (rst)
        ((timeoutEv && !isel) || supplyMonitorIrq) |=> !serviceBit;
    endproperty
    a_service_drop: assert property (p_service_drop)
        else $error("service bit survived reset or supply event");

    property p_locked;
        @(posedge clk) disable iff (rst)
        s_locked_write |=> ($stable(pre) && $stable(isel));
    endproperty
    a_locked: assert property (p_locked)
        else $error("locked control write changed the register");

    property p_magic_value;
        @(posedge clk) disable iff (rst)
        (ctrlLoad && wByte == 8'h72)
            |=> (pre == 4'h7 && !isel && serviceBit && tickCnt == '0);
    endproperty
    a_magic_value: assert property (p_magic_value)
        else $error("72H did not start a 2 s reset-mode watchdog");

endmodule // wdt_ctrl

// ---- core/wdt_pkg.sv ----
// Purpose: shared constants for the watchdog control block
// Assumes: 40 MHz system clock, 32.768 kHz crystal timebase
// Notes:   register offsets are byte addresses on the AXI4-Lite slave
package wdt_pkg;

    // bus geometry
    localparam int          WDT_ADDR_W       = 8;
    localparam int          WDT_DATA_W       = 32;

    // register byte offsets
    localparam logic [7:0]  WDT_OFS_CTRL     = 8'h00;
    localparam logic [7:0]  WDT_OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0]  WDT_OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0]  WDT_OFS_COUNT    = 8'h0C;

    // watchdog_control field positions
    localparam int          WDT_PRE_MSB      = 7;
    localparam int          WDT_PRE_LSB      = 4;
    localparam int          WDT_BIT_ISEL     = 3;
    localparam int          WDT_BIT_STATUS   = 2;
    localparam int          WDT_BIT_SERVICE  = 1;
    localparam int          WDT_BIT_UNLOCK   = 0;

    // watchdog_control value after power-on reset
    localparam logic [7:0]  WDT_CTRL_RESET   = 8'h10;

    // prescale codes
    localparam logic [3:0]  WDT_PRE_IMMED    = 4'h8;
    localparam int          WDT_BASE_SHIFT   = 9;
    localparam int          WDT_CNT_W        = 17;

    // interrupt status / mask bit positions
    localparam int          WDT_EV_TIMEOUT   = 0;
    localparam int          WDT_EV_SYSRESET  = 1;
    localparam int          WDT_EV_REFUSED   = 2;
    localparam int          WDT_EV_W         = 3;
    localparam logic [2:0]  WDT_EV_RESET     = 3'h0;

    // timebase: crystal and system clock rates
    localparam int          WDT_CLK_HZ       = 40000000;
    localparam int          WDT_XTAL_HZ      = 32768;

    // length of the system reset request, in clock cycles
    localparam int          WDT_RST_PULSE    = 4;
    localparam logic [2:0]  WDT_RST_PULSE_N  = 3'h4;

    // AXI responses
    localparam logic [1:0]  WDT_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  WDT_RESP_SLVERR  = 2'h2;

endpackage : wdt_pkg

// ---- core/wdt_tick_gen.sv ----
// Purpose: crystal-rate tick from the system clock
// Assumes: TICK_NUM below TICK_DEN
// Notes:   phase accumulator, so the average rate is exact with no drift
module wdt_tick_gen
#(
    parameter int unsigned TICK_NUM = 32768,
    parameter int unsigned TICK_DEN = 40000000
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // one-cycle pulse at the crystal rate
    output logic      xtalTick
);
    import wdt_pkg::*;

    logic [31:0] phase;
    logic [32:0] sum;

    // accumulate, wrap at the denominator
    assign sum = {1'b0, phase} + 33'(TICK_NUM);

    // phase register and tick flop
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase    <= 32'h0;
            xtalTick <= 1'b0;
        end
        else if (sum >= 33'(TICK_DEN))
        begin
            phase    <= 32'(sum - 33'(TICK_DEN));
            xtalTick <= 1'b1;
        end
        else
        begin
            phase    <= sum[31:0];
            xtalTick <= 1'b0;
        end
    end

endmodule // wdt_tick_gen

// ---- verif/tb_watchdog_timer_control.sv ----
// Purpose: self-checking bench for the watchdog control block
// Assumes: a crystal tick every second clock keeps timeouts short
// Notes:   bus tasks hold each channel until its own ready is seen
module tb_watchdog_timer_control
    import wdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed
    {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [1:0]  rsp;
    } wdt_row_t;

    logic        clk, rst, supplyMonitorIrq;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic        sysResetReq, wdtIrq, wdtIrqPrioHigh, irq;
    int          mismatches, nCompared, n;

    // locked writes, a disarming read, W1C status, unmapped place, mask
    wdt_row_t rows [14] = '{
        '{1'h0, 8'h00, 32'h10, 2'h0}, '{1'h1, 8'h00, 32'h72, 2'h0},
        '{1'h0, 8'h00, 32'h10, 2'h0}, '{1'h0, 8'h04, 32'h04, 2'h0},
        '{1'h1, 8'h00, 32'h01, 2'h0}, '{1'h0, 8'h0C, 32'h00, 2'h0},
        '{1'h1, 8'h00, 32'h72, 2'h0}, '{1'h0, 8'h00, 32'h10, 2'h0},
        '{1'h1, 8'h04, 32'h07, 2'h0}, '{1'h0, 8'h04, 32'h00, 2'h0},
        '{1'h0, 8'h14, 32'h00, 2'h2}, '{1'h1, 8'h14, 32'hFF, 2'h2},
        '{1'h1, 8'h08, 32'h07, 2'h0}, '{1'h0, 8'h08, 32'h07, 2'h0}};

    // tick every second cycle: the base period is 1024 clocks
    wdt_ctrl #(.TICK_NUM(1), .TICK_DEN(2)) i_dut (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .supplyMonitorIrq, .sysResetReq,
        .wdtIrq, .wdtIrqPrioHigh, .irq);

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        nCompared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one write; address and data are released each at its own ready
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ad = 1'b0;
        logic wd = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge clk);
            ad |= s_axi_awready;
            wd |= s_axi_wready;
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // unlock, then the guarded control write right after it; the bench
    // is the only master, so nothing can slip in between
    task automatic ld(input logic [31:0] v);
        axw(WDT_OFS_CTRL, 32'h01);
        axw(WDT_OFS_CTRL, v);
    endtask

    // cycles until a reset request or the watchdog interrupt shows
    task automatic wev;
        n = 0;
        while (!(sysResetReq || wdtIrq) && n < 9000)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    // a hang is cut short well after the longest expected run
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    initial
    begin
        rst = 1'b1;
        {s_axi_arvalid, s_axi_rready, supplyMonitorIrq} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chk("prio", wdtIrqPrioHigh, 32'h1);
        foreach (rows[i])
        begin
            if (rows[i].w)
                axw(rows[i].a, rows[i].d);
            else
            begin
                axr(rows[i].a);
                chk("rdata", rdv, rows[i].d);
            end
            chk("resp", {30'h0, rsp}, {30'h0, rows[i].rsp});
        end
        ld(32'h72);
        axr(WDT_OFS_CTRL);
        chk("ctrl 72", rdv, 32'h72);
        // period doubles per prescale step; pulse and flags after it
        for (int p = 0; p < 2; p++)
        begin
            ld({24'h0, p[3:0], 4'h2});
            wev();
            chk("period", n > (1018 << p) && n < (1030 << p), 1);
            chk("irq mode", wdtIrq, 32'h0);
            n = 0;
            while (sysResetReq)
            begin
                @(posedge clk);
                n++;
            end
            chk("pulse", n, 32'h4);
            axr(WDT_OFS_CTRL);
            chk("ctrl", rdv, {24'h0, p[3:0], 4'h4});
            chk("kept", rdv[2], 32'h1);
        end
        // servicing part way through restarts the full period
        ld(32'h02);
        repeat (700) @(posedge clk);
        ld(32'h02);
        wev();
        chk("serviced", n > 1018 && n < 1030, 1);
        // clear stale events so the interrupt below is a fresh one
        axw(WDT_OFS_IRQ_STAT, 32'h7);
        axw(WDT_OFS_IRQ_MASK, 32'h1);
        ld(32'h0A);
        wev();
        chk("int period", n > 1018 && n < 1030, 1);
        chk("no reset", sysResetReq, 32'h0);
        chk("wdt irq", wdtIrq, 32'h1);
        axr(WDT_OFS_CTRL);
        chk("ctrl int", rdv, 32'h0E);
        chk("irq on", irq, 32'h1);
        axw(WDT_OFS_IRQ_STAT, 32'h1);
        chk("irq clr", irq, 32'h0);
        axw(WDT_OFS_IRQ_MASK, 32'h0);
        repeat (1100) @(posedge clk);
        axr(WDT_OFS_IRQ_STAT);
        chk("rerun", rdv, 32'h1);
        chk("masked", irq, 32'h0);
        chk("unmasked", wdtIrq, 32'h1);
        @(posedge clk);
        supplyMonitorIrq <= 1'b1;
        @(posedge clk);
        supplyMonitorIrq <= 1'b0;
        axr(WDT_OFS_CTRL);
        chk("monitor", rdv, 32'h0C);
        ld(32'h82);
        wev();
        chk("immediate", n < 8 && sysResetReq, 1);
        // hardware reset in mid-run restores the power-on value
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        axr(WDT_OFS_CTRL);
        chk("hw reset", rdv, {24'h0, WDT_CTRL_RESET});
        chk("req cut", sysResetReq, 32'h0);
        tally_and_finish();
    end
endmodule // tb_watchdog_timer_control
